//--- hw/idlog_params.svh
// Offsets, field positions, codes and limits of the identify and log completion block.
`ifndef IDLOG_PARAMS_SVH
`define IDLOG_PARAMS_SVH
`define STRUCT_BYTES     4096
`define STRUCT_LAST_WORD (`STRUCT_BYTES / 4 - 1)
`define PAGE_BYTES       13'h1000
`define SEL_MSB          7
`define SEL_LSB          0
`define CTRL_ID_MSB      31
`define CTRL_ID_LSB      16
`define SEL_NS           8'h00
`define SEL_CTRL         8'h01
`define SEL_NS_LIST      8'h02
`define SEL_NS_ALL       8'h10
`define SEL_NS_ANY       8'h11
`define SEL_CTRL_NS      8'h12
`define SEL_CTRL_ALL     8'h13
`define NS_ID_COMMON     32'h0FFFFFFF
`define NS_LIST_MAX      1024
`define CTRL_LIST_MAX    2047
`define NS_SCAN_LIMIT    32'h00000400
`define CTRL_SCAN_LIMIT  32'h0000FFFE
`define SCT_GENERIC      3'h0
`define SCT_CMD          3'h1
`define SC_OK            8'h00
`define SC_BAD_FIELD     8'h02
`define SC_BAD_LOG       8'h09
`define SC_BAD_NS        8'h0B
`endif

//--- hw/idlog_pkg.sv
// Types shared by the identify and log completion block.
package idlog_pkg;
  typedef enum logic {op_get_log, op_identify} cmd_op_type;
  typedef enum logic [1:0] {fill_zero, fill_src, fill_list} fill_type;
  typedef enum logic [1:0] {src_ns, src_ns_common, src_ctrl, src_log} src_kind_type;
  typedef enum logic [1:0] {
    scan_ns_active, scan_ns_present, scan_ctrl_on_ns, scan_ctrl_all
  } scan_kind_type;
  typedef struct packed {
    cmd_op_type  op;
    logic [31:0] namespace_id_field;
    logic [31:0] command_dword_ten;
    logic [63:0] first_buffer_pointer;
    logic [63:0] second_buffer_pointer;
    logic [7:0]  log_id;
    logic [9:0]  log_numd;
  } cmd_type;
  typedef struct packed {
    logic [31:0] ns_id;
    logic [7:0]  log_id;
  } query_type;
  typedef struct packed {
    logic [63:0] addr;
    logic [31:0] data;
  } wr_type;
  typedef struct packed {
    logic [2:0] sct;
    logic [7:0] sc;
  } cpl_type;
endpackage

//--- hw/id_list_scanner.sv
// Walks candidate identifiers upward and returns the next one that the probe marks as a hit.
module id_list_scanner (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Control
  input  wire logic        start,
  input  wire logic        strict,
  input  wire logic [31:0] lo,
  input  wire logic [31:0] limit,
  input  wire logic        next,
  // Probe
  output logic      [31:0] scan_id,
  input  wire logic        scan_hit,
  // Result
  output logic             result,
  output logic      [31:0] result_id,
  output logic             empty
);
  logic busy;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scan_id   <= 32'h0;
      busy      <= 1'b0;
      result    <= 1'b0;
      result_id <= 32'h0;
      empty     <= 1'b0;
    end else begin
      result <= 1'b0;
      if (start) begin
        scan_id <= strict ? lo + 32'h1 : lo;
        empty   <= strict && (lo == 32'hFFFFFFFF);
        busy    <= 1'b0;
      end else if (next) begin
        busy <= 1'b1;
      end else if (busy) begin
        // Candidates run upward, so the list comes out in ascending order.
        if (scan_id > limit) begin
          empty     <= 1'b1;
          result    <= 1'b1;
          result_id <= 32'h0;
          busy      <= 1'b0;
        end else if (scan_hit) begin
          result    <= 1'b1;
          result_id <= scan_id;
          scan_id   <= scan_id + 32'h1;
          busy      <= 1'b0;
        end else begin
          scan_id <= scan_id + 32'h1;
        end
      end
    end
  end
endmodule

//--- hw/identify_and_log_completion.sv
`include "idlog_params.svh"
module identify_and_log_completion
  import idlog_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Command
  input  wire logic        cmd_valid,
  input  wire cmd_type     cmd,
  output logic             cmd_ready,
  // Status queries
  output query_type        query,
  input  wire logic        ns_attached,
  input  wire logic        ns_present,
  input  wire logic        log_page_valid,
  input  wire logic        ns_mgmt_en,
  // Structure source
  output logic             src_rd,
  output src_kind_type     src_kind,
  output logic      [9:0]  src_index,
  input  wire logic [31:0] src_data,
  // Identifier probe
  output scan_kind_type    scan_kind,
  output logic      [31:0] scan_id,
  input  wire logic        scan_hit,
  // Host memory writes
  output logic             wr_valid,
  output wr_type           wr,
  input  wire logic        wr_ready,
  // Completion
  output logic             cpl_valid,
  output cpl_type          cpl,
  input  wire logic        cpl_ready
);
  typedef enum logic [3:0] {
    st_idle, st_check, st_prime, st_fetch, st_src_req, st_src_cap,
    st_scan, st_write, st_wr_ack, st_count, st_cpl, st_cpl_ack
  } state_type;

  state_type   state;
  cmd_op_type  op;
  fill_type    fill;
  cpl_type     status;
  logic [7:0]  sel;
  logic [15:0] ctrl_id;
  logic [63:0] buf_ptr_one;
  logic [63:0] buf_ptr_two;
  logic [9:0]  last_wi;
  logic [9:0]  wi;
  logic        is_ctrl;
  logic        half;
  logic        counted;
  logic [31:0] word_buf;
  logic [15:0] first_hi;
  logic [10:0] list_cnt;
  logic        scan_start;
  logic        scan_next;
  logic        scan_strict;
  logic [31:0] scan_lo;
  logic [31:0] scan_limit;
  logic        sc_result;
  logic [31:0] sc_result_id;
  logic        sc_empty;
  logic        entry_now;
  logic [15:0] entry_val;
  logic [10:0] wr_count;

  // A buffer that starts mid page spills into the page that the second pointer names.
  function automatic logic [63:0] host_addr(input logic [63:0] p1,
                                            input logic [63:0] p2,
                                            input logic [9:0]  w);
    logic [12:0] off;
    logic [12:0] room;
    off  = {1'b0, w, 2'b00};
    room = `PAGE_BYTES - {1'b0, p1[11:0]};
    if (off < room)
      return p1 + 64'(off);
    return p2 + 64'(off - room);
  endfunction

  id_list_scanner u_scanner (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .start     (scan_start),
    .strict    (scan_strict),
    .lo        (scan_lo),
    .limit     (scan_limit),
    .next      (scan_next),
    .scan_id   (scan_id),
    .scan_hit  (scan_hit),
    .result    (sc_result),
    .result_id (sc_result_id),
    .empty     (sc_empty)
  );

  // A list entry is ready now, either a found identifier or a zero filler.
  always_comb begin
    entry_now = 1'b0;
    entry_val = 16'h0;
    if (state == st_fetch && fill == fill_list &&
        ((is_ctrl && !half && wi == 10'h0) || sc_empty)) begin
      entry_now = 1'b1;
    end else if (state == st_scan && sc_result) begin
      entry_now = 1'b1;
      entry_val = sc_result_id[15:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state       <= st_idle;
      cmd_ready   <= 1'b1;
      op          <= op_get_log;
      fill        <= fill_zero;
      status      <= '0;
      sel         <= 8'h0;
      ctrl_id     <= 16'h0;
      buf_ptr_one <= 64'h0;
      buf_ptr_two <= 64'h0;
      last_wi     <= 10'h0;
      wi          <= 10'h0;
      is_ctrl     <= 1'b0;
      half        <= 1'b0;
      counted     <= 1'b0;
      word_buf    <= 32'h0;
      first_hi    <= 16'h0;
      list_cnt    <= 11'h0;
      query       <= '0;
      src_rd      <= 1'b0;
      src_kind    <= src_ns;
      src_index   <= 10'h0;
      scan_kind   <= scan_ns_active;
      scan_start  <= 1'b0;
      scan_next   <= 1'b0;
      scan_strict <= 1'b0;
      scan_lo     <= 32'h0;
      scan_limit  <= 32'h0;
      wr_valid    <= 1'b0;
      wr          <= '0;
      cpl_valid   <= 1'b0;
      cpl         <= '0;
    end else begin
      src_rd     <= 1'b0;
      scan_start <= 1'b0;
      scan_next  <= 1'b0;
      case (state)
        st_idle: begin
          if (cmd_valid) begin
            cmd_ready    <= 1'b0;
            op           <= cmd.op;
            query.ns_id  <= cmd.namespace_id_field;
            query.log_id <= cmd.log_id;
            sel          <= cmd.command_dword_ten[`SEL_MSB:`SEL_LSB];
            ctrl_id      <= cmd.command_dword_ten[`CTRL_ID_MSB:`CTRL_ID_LSB];
            buf_ptr_one  <= cmd.first_buffer_pointer;
            buf_ptr_two  <= cmd.second_buffer_pointer;
            last_wi      <= cmd.op == op_identify ? 10'(`STRUCT_LAST_WORD) : cmd.log_numd;
            wi           <= 10'h0;
            half         <= 1'b0;
            counted      <= 1'b0;
            is_ctrl      <= 1'b0;
            list_cnt     <= 11'h0;
            status       <= '{sct: `SCT_GENERIC, sc: `SC_OK};
            state        <= st_check;
          end
        end
        st_check: begin
          // The scanner restarts here so its empty flag is fresh by the first fetch.
          scan_start  <= 1'b1;
          state       <= st_fetch;
          fill        <= fill_src;
          scan_strict <= 1'b1;
          scan_lo     <= query.ns_id;
          scan_limit  <= `NS_SCAN_LIMIT;
          if (op == op_get_log) begin
            src_kind <= src_log;
            if (!log_page_valid) begin
              status <= '{sct: `SCT_CMD, sc: `SC_BAD_LOG};
              state  <= st_cpl;
            end
          end else begin
            case (sel)
              `SEL_NS: begin
                if (query.ns_id == `NS_ID_COMMON && ns_mgmt_en)
                  src_kind <= src_ns_common;
                else if (ns_attached)
                  src_kind <= src_ns;
                else
                  fill <= fill_zero;
              end
              `SEL_CTRL: src_kind <= src_ctrl;
              `SEL_NS_LIST: begin
                fill      <= fill_list;
                scan_kind <= scan_ns_active;
                state     <= st_prime;
              end
              `SEL_NS_ALL, `SEL_NS_ANY, `SEL_CTRL_NS, `SEL_CTRL_ALL: begin
                if (!ns_mgmt_en) begin
                  status <= '{sct: `SCT_GENERIC, sc: `SC_BAD_FIELD};
                  state  <= st_cpl;
                end else if (sel == `SEL_NS_ANY) begin
                  src_kind <= src_ns;
                  if (!ns_present) begin
                    status <= '{sct: `SCT_GENERIC, sc: `SC_BAD_NS};
                    state  <= st_cpl;
                  end
                end else begin
                  fill  <= fill_list;
                  state <= st_prime;
                  if (sel == `SEL_NS_ALL) begin
                    scan_kind <= scan_ns_present;
                  end else begin
                    is_ctrl     <= 1'b1;
                    scan_strict <= 1'b0;
                    scan_lo     <= {16'h0, ctrl_id};
                    scan_limit  <= `CTRL_SCAN_LIMIT;
                    scan_kind   <= sel == `SEL_CTRL_NS ? scan_ctrl_on_ns : scan_ctrl_all;
                  end
                end
              end
              default: begin
                status <= '{sct: `SCT_GENERIC, sc: `SC_BAD_FIELD};
                state  <= st_cpl;
              end
            endcase
          end
        end
        st_prime: begin
          state <= st_fetch;
        end
        st_fetch: begin
          if (fill == fill_zero) begin
            word_buf <= 32'h0;
            state    <= st_write;
          end else if (fill == fill_src) begin
            src_rd    <= 1'b1;
            src_index <= wi;
            state     <= st_src_req;
          end else if (!entry_now) begin
            scan_next <= 1'b1;
            state     <= st_scan;
          end
        end
        st_src_req: state <= st_src_cap;
        st_src_cap: begin
          word_buf <= src_data;
          state    <= st_write;
        end
        st_scan: ;
        st_write: begin
          wr_valid <= 1'b1;
          wr.addr  <= host_addr(buf_ptr_one, buf_ptr_two, wi);
          wr.data  <= word_buf;
          state    <= st_wr_ack;
        end
        st_wr_ack: begin
          if (wr_ready) begin
            wr_valid <= 1'b0;
            half     <= 1'b0;
            if (counted || (wi == last_wi && !is_ctrl)) begin
              state <= st_cpl;
            end else if (wi == last_wi) begin
              state <= st_count;
            end else begin
              wi    <= wi + 10'h1;
              state <= st_fetch;
            end
          end
        end
        st_count: begin
          // Entry zero of a controller list carries the number of identifiers found.
          word_buf <= {first_hi, 5'h0, list_cnt};
          wi       <= 10'h0;
          counted  <= 1'b1;
          state    <= st_write;
        end
        st_cpl: begin
          cpl_valid <= 1'b1;
          cpl       <= status;
          state     <= st_cpl_ack;
        end
        st_cpl_ack: begin
          if (cpl_ready) begin
            cpl_valid <= 1'b0;
            cmd_ready <= 1'b1;
            state     <= st_idle;
          end
        end
        default: state <= st_idle;
      endcase
      if (entry_now) begin
        if (state == st_scan && sc_result && !sc_empty)
          list_cnt <= list_cnt + 11'h1;
        if (!is_ctrl) begin
          word_buf <= {16'h0, entry_val};
          state    <= st_write;
        end else if (!half) begin
          word_buf[15:0] <= entry_val;
          half           <= 1'b1;
          state          <= st_fetch;
        end else begin
          word_buf[31:16] <= entry_val;
          if (wi == 10'h0)
            first_hi <= entry_val;
          state <= st_write;
        end
      end
    end
  end

  // Writes acknowledged for the command in flight.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)
      wr_count <= 11'h0;
    else if (state == st_idle)
      wr_count <= 11'h0;
    else if (wr_valid && wr_ready)
      wr_count <= wr_count + 11'h1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  cpl_after_data_a: assert property (cpl_valid |-> !wr_valid)
    else $error("completion raised while a write is pending");
  bad_log_status_a: assert property (
    state == st_check && op == op_get_log && !log_page_valid
    |-> ##2 cpl_valid && cpl.sct == `SCT_CMD && cpl.sc == `SC_BAD_LOG)
    else $error("invalid log page not answered with 9h");
  struct_size_a: assert property (
    state == st_cpl && op == op_identify && status.sc == `SC_OK
    |-> wr_count == (is_ctrl ? 11'h401 : 11'h400))
    else $error("identify did not write the whole structure");
  zero_struct_a: assert property (wr_valid && fill == fill_zero |-> wr.data == 32'h0)
    else $error("inactive namespace structure not zero");
  ns_list_order_a: assert property (
    state == st_scan && sc_result && !sc_empty && !is_ctrl
    |-> sc_result_id > query.ns_id)
    else $error("namespace list entry not above the given identifier");
  ctrl_list_floor_a: assert property (
    state == st_scan && sc_result && !sc_empty && is_ctrl
    |-> sc_result_id >= {16'h0, ctrl_id} && list_cnt < 11'(`CTRL_LIST_MAX))
    else $error("controller list entry below the field or list too long");
  reserved_sel_a: assert property (
    state == st_check && op == op_identify && sel > `SEL_CTRL_ALL
    |=> state == st_cpl ##1 cpl_valid && cpl.sc == `SC_BAD_FIELD && wr_count == 11'h0)
    else $error("reserved selector not rejected");
  mgmt_accept_a: assert property (
    state == st_check && op == op_identify && ns_mgmt_en &&
    (sel == `SEL_NS_ALL || sel == `SEL_CTRL_NS || sel == `SEL_CTRL_ALL)
    |=> state == st_prime)
    else $error("management selector refused");
  bad_ns_a: assert property (
    state == st_check && op == op_identify && sel == `SEL_NS_ANY &&
    ns_mgmt_en && !ns_present
    |-> ##2 cpl_valid && cpl.sc == `SC_BAD_NS)
    else $error("invalid namespace not failed");

  log_ok_c: cover property (cpl_valid && op == op_get_log && cpl.sc == `SC_OK);
  ctrl_list_c: cover property (state == st_count ##[1:8] cpl_valid);
  reserved_c: cover property (cpl_valid && cpl.sc == `SC_BAD_FIELD);
  zero_fill_c: cover property (state == st_fetch && fill == fill_list && sc_empty);
endmodule

//--- bench/host_model.sv
// Host side model: buffer memory, completion intake, status answers and structure source.
module host_model
  import idlog_pkg::*;
(
  // Clock
  input  wire logic        core_clk,
  // Bench control
  input  wire logic        slow,
  input  wire logic        clear,
  input  wire logic [15:0] att,
  input  wire logic [15:0] prs,
  input  wire logic [15:0] ctl,
  input  wire logic [15:0] ctl_ns,
  // Status answers
  input  wire query_type   query,
  output logic             ns_attached,
  output logic             ns_present,
  output logic             log_page_valid,
  // Structure source
  input  wire logic        src_rd,
  input  wire src_kind_type src_kind,
  input  wire logic [9:0]  src_index,
  output logic      [31:0] src_data,
  // Identifier probe
  input  wire scan_kind_type scan_kind,
  input  wire logic [31:0] scan_id,
  output logic             scan_hit,
  // Host memory and completion
  input  wire logic        wr_valid,
  input  wire wr_type      wr,
  output logic             wr_ready,
  input  wire logic        cpl_valid,
  output logic             cpl_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [63:0]];
  int          n_wr = 0;
  logic [31:0] held = 32'h0;
  logic        fresh = 1'b0;
  logic [1:0]  tick = 2'h0;
  always_comb ns_attached = query.ns_id < 32'h10 && att[query.ns_id[3:0]];
  always_comb ns_present = query.ns_id < 32'h10 && prs[query.ns_id[3:0]];
  always_comb log_page_valid = query.log_id inside {[8'h01:8'h03]};
  always_comb begin
    case (scan_kind)
      scan_ns_active:  scan_hit = scan_id < 32'h10 && att[scan_id[3:0]];
      scan_ns_present: scan_hit = scan_id < 32'h10 && prs[scan_id[3:0]];
      scan_ctrl_on_ns: scan_hit = scan_id[31:4] == 28'hFFF && ctl_ns[scan_id[3:0]];
      default:         scan_hit = scan_id[31:4] == 28'hFFF && ctl[scan_id[3:0]];
    endcase
  end
  // Slow mode stalls both writes and completions; a stale source word reads inverted.
  always_comb wr_ready = !slow || tick[0];
  always_comb cpl_ready = !slow || tick == 2'h3;
  always_comb src_data = fresh ? held : ~held;
  always @(posedge core_clk) begin
    tick <= tick + 2'h1;
    fresh <= src_rd;
    if (src_rd) begin
      held <= {src_kind, 20'hA5C3E, src_index};
    end
    if (clear) begin
      mem.delete();
      n_wr <= 0;
    end else if (wr_valid && wr_ready) begin
      mem[wr.addr] = wr.data;
      n_wr <= n_wr + 1;
    end
  end
endmodule

//--- bench/testbench.sv
// Self-checking bench for the identify and log completion block.
`include "idlog_params.svh"
module testbench
  import idlog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] page_two = 64'h0000_0002_0000_0000;
  localparam int          limit = 90000;
  logic          core_clk, rst_b, cmd_valid, cmd_ready, ns_attached, ns_present;
  logic          log_page_valid, ns_mgmt_en, src_rd, scan_hit, wr_valid, wr_ready;
  logic          cpl_valid, cpl_ready, slow, clear;
  cmd_type       cmd;
  query_type     query;
  src_kind_type  src_kind;
  scan_kind_type scan_kind;
  logic [9:0]    src_index;
  logic [31:0]   src_data, scan_id;
  wr_type        wr;
  cpl_type       cpl;
  logic [15:0]   r, att, prs, ctl, ctl_ns, cid, q;
  logic [63:0]   cur_p1;
  logic [31:0]   e [1024];
  logic [7:0]    rsv [6] = '{8'h03, 8'h0F, 8'h14, 8'h1F, 8'h20, 8'hFF};
  int            n_fail = 0, tests_run = 0, cycles = 0;

  identify_and_log_completion DUT (.core_clk(core_clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .query(query),
    .ns_attached(ns_attached), .ns_present(ns_present), .log_page_valid(log_page_valid),
    .ns_mgmt_en(ns_mgmt_en), .src_rd(src_rd), .src_kind(src_kind), .src_index(src_index),
    .src_data(src_data), .scan_kind(scan_kind), .scan_id(scan_id), .scan_hit(scan_hit),
    .wr_valid(wr_valid), .wr(wr), .wr_ready(wr_ready), .cpl_valid(cpl_valid), .cpl(cpl),
    .cpl_ready(cpl_ready));
  host_model host (.core_clk(core_clk), .slow(slow), .clear(clear), .att(att), .prs(prs),
    .ctl(ctl), .ctl_ns(ctl_ns), .query(query), .ns_attached(ns_attached),
    .ns_present(ns_present), .log_page_valid(log_page_valid), .src_rd(src_rd),
    .src_kind(src_kind), .src_index(src_index), .src_data(src_data), .scan_kind(scan_kind),
    .scan_id(scan_id), .scan_hit(scan_hit), .wr_valid(wr_valid), .wr(wr),
    .wr_ready(wr_ready), .cpl_valid(cpl_valid), .cpl_ready(cpl_ready));

  function automatic logic [15:0] rnd();
    r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    return r;
  endfunction
  function automatic logic [31:0] pat(input logic [1:0] k, input int i);
    return {k, 20'hA5C3E, 10'(i)};
  endfunction
  // Words past the end of the first page continue at the start of the second page.
  function automatic logic [63:0] addr_of(input int i);
    logic [12:0] off;
    off = {1'b0, cur_p1[11:0]} + 13'(4 * i);
    return off < `PAGE_BYTES ? cur_p1 + 64'(4 * i) : page_two + 64'(off - `PAGE_BYTES);
  endfunction
  task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
    tests_run++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", nm, x, g);
    end
  endtask
  task automatic check_data(input string nm, input int cnt);
    logic [63:0] a;
    for (int i = 0; i < cnt; i++) begin
      a = addr_of(i);
      chk(nm, {32'h0, e[i]}, host.mem.exists(a) ? {32'h0, host.mem[a]} : 64'hX);
    end
  endtask
  // Modes: 0 no data, 1 zeros, 2 namespace, 3 common, 4 controller, 5..8 lists.
  task automatic build(input int mode, input logic [31:0] n);
    logic [15:0] m;
    logic [15:0] h [2048];
    int          j;
    j = mode >= 7 ? 1 : 0;
    m = mode == 5 ? att : mode == 6 ? prs : mode == 7 ? ctl_ns : ctl;
    foreach (h[i]) h[i] = 16'h0;
    foreach (e[i]) e[i] = mode inside {[2:4]} ? pat(2'(mode - 2), i) : 32'h0;
    // Namespace identifier 15 can be a hit; controller FFFFh lies above the scan limit.
    for (int b = 0; b < 16; b++) begin
      if (mode inside {5, 6} && b > 0 && m[b] && 32'(b) > n) begin
        e[j] = 32'(b);
        j++;
      end
      if (mode >= 7 && b < 15 && m[b] && 16'hFFF0 + 16'(b) >= cid) begin
        h[j] = 16'hFFF0 + 16'(b);
        j++;
      end
    end
    if (mode >= 7) begin
      h[0] = 16'(j - 1);
      foreach (e[i]) e[i] = {h[2 * i + 1], h[2 * i]};
    end
  endtask
  task automatic run(input cmd_op_type op, input logic [31:0] n, input logic [31:0] d10,
                     input logic [7:0] lid, input logic [9:0] nd, output cpl_type cp,
                     output int nw);
    do @(negedge core_clk); while (cmd_ready !== 1'b1);
    q = rnd();
    cur_p1 = {32'h0000_0001, 20'h0, q[9:0], 2'h0};
    @(posedge core_clk);
    clear <= 1'b1;
    slow <= q[15];
    @(posedge core_clk);
    clear <= 1'b0;
    cmd_valid <= 1'b1;
    cmd <= '{op, n, d10, cur_p1, page_two, lid, nd};
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    do @(negedge core_clk); while (cpl_valid !== 1'b1);
    cp = cpl;
    nw = host.n_wr;
    do @(negedge core_clk); while (cpl_valid === 1'b1);
  endtask
  task automatic log_read(input logic [7:0] lid, input logic [9:0] nd, input logic ok);
    cpl_type cp;
    int      nw;
    run(op_get_log, 32'h0, 32'h0, lid, nd, cp, nw);
    chk("log status", ok ? 64'h0 : 64'({`SCT_CMD, `SC_BAD_LOG}), 64'(cp));
    chk("log writes", ok ? 64'(nd) + 64'h1 : 64'h0, 64'(nw));
    foreach (e[i]) e[i] = pat(src_log, i);
    if (ok) check_data("log data", int'(nd) + 1);
  endtask
  task automatic ident(input string nm, input logic [7:0] sel, input logic [31:0] n,
                       input logic [15:0] c, input int mode, input logic [7:0] sc);
    cpl_type cp;
    int      nw;
    build(mode, n);
    q = rnd();
    run(op_identify, n, {c, 8'h00, sel}, q[7:0], q[9:0], cp, nw);
    chk({nm, " status"}, 64'({`SCT_GENERIC, sc}), 64'(cp));
    chk({nm, " writes"}, mode == 0 ? 64'h0 : mode >= 7 ? 64'h401 : 64'h400, 64'(nw));
    if (mode != 0) check_data(nm, 1024);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == limit) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    r = 16'h000B;
    {rst_b, cmd_valid, slow, clear} = 4'h0;
    cmd = '0;
    ns_mgmt_en = 1'b1;
    att = (rnd() & 16'hFFE4) | 16'h0002;
    prs = att | (rnd() & 16'hFFEE) | 16'h0008;
    ctl = rnd() & 16'h7FFF;
    ctl_ns = ctl & rnd();
    q = rnd();
    cid = 16'hFFF0 + {13'h0, q[2:0]};
    ctl = ctl | (16'h0001 << q[2:0]);
    ctl_ns = ctl_ns | (16'h0001 << q[2:0]);
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    log_read(8'h01, 10'(rnd() & 16'h000F), 1'b1);
    log_read(8'h03, 10'h000, 1'b1);
    log_read(8'h00, 10'h007, 1'b0);
    log_read(8'h80, 10'h007, 1'b0);
    ident("ns attached", `SEL_NS, 32'h1, 16'h0, 2, `SC_OK);
    ident("ns inactive", `SEL_NS, 32'h3, 16'h0, 1, `SC_OK);
    ident("ns common", `SEL_NS, `NS_ID_COMMON, 16'h0, 3, `SC_OK);
    ident("controller", `SEL_CTRL, 32'h0, 16'h0, 4, `SC_OK);
    ident("active list", `SEL_NS_LIST, 32'(rnd() & 16'h7), 16'h0, 5, `SC_OK);
    ident("present list", `SEL_NS_ALL, 32'(rnd() & 16'h7), 16'h0, 6, `SC_OK);
    ident("any ns", `SEL_NS_ANY, 32'h3, 16'h0, 2, `SC_OK);
    ident("absent ns", `SEL_NS_ANY, 32'h4, 16'h0, 0, `SC_BAD_NS);
    ident("ctrl on ns", `SEL_CTRL_NS, 32'h1, cid, 7, `SC_OK);
    ident("all ctrl", `SEL_CTRL_ALL, 32'h0, cid, 8, `SC_OK);
    foreach (rsv[i]) ident("reserved", rsv[i], 32'h1, 16'h0, 0, `SC_BAD_FIELD);
    ident("random reserved", 8'h20 | 8'(rnd()), 32'h1, 16'h0, 0, `SC_BAD_FIELD);
    @(posedge core_clk);
    ns_mgmt_en <= 1'b0;
    ident("no management", `SEL_NS_ALL, 32'h0, 16'h0, 0, `SC_BAD_FIELD);
    end_of_test();
  end
endmodule
